// File: tcse_regs.vh
// register offsets, field positions and reset values of the status and event bank
// Operation
// - extra state bit 1 shows sink over-range fault with attached consumer
// - extra state bit 0 shows stabilisation running
// - kind bits 6/5 show debug provider/consumer
// - kind bit 4 shows attached consumer
// - kind bit 3 shows attached provider
// - kind bit 2 shows powered cable
// - kind bits 1/0 show headset with/without supply
// - flag 6 on orientation 00 to 01/10
// - flag 5 on line over-range with pull-down
// - flag 4 on bus supply threshold crossing
// - flag 3 on dead-battery mode change
// - flag 2 on current level change
// - flag 1 on detach
// - flag 0 on attach completion
// - second flags 6/5 request supply off/on
// - second flag 3 on stabilisation failure
// - second flag 2 on forced role failure
// - second flag 1 on forced role success
// - second flag 0 on stabilisation start
// - flags reset zero, write one clears
// - mask bit keeps flag off interrupt
// - orientation field encodes none/first/second/fault
// - current level field encodes four levels
`ifndef TCSE_REGS_VH
`define TCSE_REGS_VH
`define TCSE_OFS_MASK_A      8'h0E
`define TCSE_OFS_MASK_B      8'h0F
`define TCSE_OFS_STATE       8'h11
`define TCSE_OFS_EXTRA_STATE 8'h12
`define TCSE_OFS_KIND        8'h13
`define TCSE_OFS_FLAGS_A     8'h14
`define TCSE_OFS_FLAGS_B     8'h15
`define TCSE_RESET_VALUE     8'h00
`define TCSE_FLAGS_A_USED    8'h7F
`define TCSE_FLAGS_B_USED    8'h6F
`define TCSE_PLUG_FLIP_FIELD_NONE     2'h0
`define TCSE_PLUG_FLIP_FIELD_LINE1    2'h1
`define TCSE_PLUG_FLIP_FIELD_LINE2    2'h2
`define TCSE_PLUG_FLIP_FIELD_FAULT    2'h3
`endif

// File: tcse_flag_byte.v
// one byte of write-one-to-clear event flags with masked interrupt request
`timescale 1ns/100ps
`include "tcse_regs.vh"
module tcse_flag_byte #(
  parameter [7:0] USED = 8'hFF
) (
  input  wire       clock,
  input  wire       rst_n,
  input  wire [7:0] set_event,
  input  wire       clear_strobe,
  input  wire [7:0] clear_data,
  input  wire [7:0] mask,
  output reg  [7:0] flags,
  output wire       irq_request
);
  wire [7:0] next_flags;

  // ----------------------------------------------------------------
  // flag storage
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_bit
      // a set in the clearing cycle wins so no event is lost
      assign next_flags[i] = USED[i] &
        (set_event[i] | (flags[i] & ~(clear_strobe & clear_data[i])));
    end
  endgenerate

  // synchronous reset to zero
  always @(posedge clock) begin
    if (!rst_n) begin
      flags <= `TCSE_RESET_VALUE;
    end else begin
      flags <= next_flags;
    end
  end

  // masked flags do not raise the request, but stay visible
  assign irq_request = |(flags & ~mask);
endmodule // tcse_flag_byte

// File: tcse_status_event_regs.v
// status, attach kind and event flag registers with the active-low interrupt pin
`timescale 1ns/100ps
`include "tcse_regs.vh"
module tcse_status_event_regs (
  input  wire       clock,
  input  wire       rst_n,
  // register port from the two-wire slave
  input  wire [7:0] reg_addr,
  input  wire       reg_write,
  input  wire [7:0] reg_wdata,
  input  wire       reg_read,
  output reg  [7:0] reg_rdata,
  // detection core status
  input  wire       sink_overrange,
  input  wire       stabilise_active_flag,
  input  wire       debug_accessory_provider,
  input  wire       debug_accessory_consumer,
  input  wire       attached_consumer,
  input  wire       attached_provider,
  input  wire       powered_cable_flag,
  input  wire       headset_powered_flag,
  input  wire       headset_unpowered_flag,
  input  wire [1:0] plug_flip_field,
  input  wire [1:0] advertised_current_level,
  input  wire       dead_battery_mode,
  input  wire       bus_supply_valid,
  input  wire       bus_supply_low,
  input  wire       attached,
  input  wire       pulldown_applied,
  // detection core event pulses
  input  wire       stabilise_supply_off_req,
  input  wire       stabilise_supply_on_req,
  input  wire       stabilise_failed_event,
  input  wire       forced_role_failed_event,
  input  wire       forced_role_done_event,
  input  wire       stabilise_started_event,
  // mask registers held in the control bank
  input  wire [7:0] mask_a,
  input  wire [7:0] mask_b,
  output reg        int_n
);
  reg  [1:0] last_flip;
  reg  [1:0] last_level;
  reg        last_dead_battery;
  reg        last_supply_valid;
  reg        last_supply_low;
  reg        last_attached;
  reg        last_fault;
  reg  [7:0] extra_state_reg;
  reg  [7:0] attach_kind;
  wire [7:0] event_flags_a;
  wire [7:0] event_flags_b_reg;
  wire       irq_a;
  wire       irq_b;
  wire       plug_flip_event;
  wire       overrange_event;
  wire       bus_supply_cross_event;
  wire       dead_battery_mode_event;
  wire       current_level_event;
  wire       unplug_event;
  wire       attach_event;
  wire [7:0] set_a;
  wire [7:0] set_b;
  wire       clear_a;
  wire       clear_b;
  reg  [7:0] next_rdata;

  // ----------------------------------------------------------------
  // status registers
  // ----------------------------------------------------------------
  // live status captured each cycle, reserved bits zero
  always @(posedge clock) begin
    if (!rst_n) begin
      extra_state_reg <= `TCSE_RESET_VALUE;
      attach_kind     <= `TCSE_RESET_VALUE;
    end else begin
      extra_state_reg <= {6'h00,
                          sink_overrange & attached_consumer,
                          stabilise_active_flag};
      attach_kind     <= {1'b0,
                          debug_accessory_provider,
                          debug_accessory_consumer,
                          attached_consumer,
                          attached_provider,
                          powered_cable_flag,
                          headset_powered_flag,
                          headset_unpowered_flag};
    end
  end

  // ----------------------------------------------------------------
  // change detection
  // ----------------------------------------------------------------
  // previous values of the watched status for edge detection
  always @(posedge clock) begin
    if (!rst_n) begin
      last_flip         <= `TCSE_PLUG_FLIP_FIELD_NONE;
      last_level        <= 2'h0;
      last_dead_battery <= 1'b0;
      last_supply_valid <= 1'b0;
      last_supply_low   <= 1'b1;
      last_attached     <= 1'b0;
      last_fault        <= 1'b0;
    end else begin
      last_flip         <= plug_flip_field;
      last_level        <= advertised_current_level;
      last_dead_battery <= dead_battery_mode;
      last_supply_valid <= bus_supply_valid;
      last_supply_low   <= bus_supply_low;
      last_attached     <= attached;
      last_fault        <= sink_overrange & pulldown_applied;
    end
  end

  // only a resolved orientation out of none raises the event
  assign plug_flip_event = (last_flip == `TCSE_PLUG_FLIP_FIELD_NONE) &&
                           ((plug_flip_field == `TCSE_PLUG_FLIP_FIELD_LINE1) ||
                            (plug_flip_field == `TCSE_PLUG_FLIP_FIELD_LINE2));
  assign overrange_event         = sink_overrange & pulldown_applied & ~last_fault;
  assign bus_supply_cross_event  = (bus_supply_valid ^ last_supply_valid) |
                                   (bus_supply_low ^ last_supply_low);
  assign dead_battery_mode_event = dead_battery_mode ^ last_dead_battery;
  assign current_level_event     = advertised_current_level != last_level;
  assign unplug_event            = last_attached & ~attached;
  assign attach_event            = attached & ~last_attached;

  assign set_a = {1'b0, plug_flip_event, overrange_event, bus_supply_cross_event,
                  dead_battery_mode_event, current_level_event, unplug_event,
                  attach_event};
  assign set_b = {1'b0, stabilise_supply_off_req, stabilise_supply_on_req,
                  1'b0, stabilise_failed_event,
                  forced_role_failed_event,
                  forced_role_done_event,
                  stabilise_started_event};

  // ----------------------------------------------------------------
  // event flag bytes
  // ----------------------------------------------------------------
  assign clear_a = reg_write && (reg_addr == `TCSE_OFS_FLAGS_A);
  assign clear_b = reg_write && (reg_addr == `TCSE_OFS_FLAGS_B);

  tcse_flag_byte #(.USED(`TCSE_FLAGS_A_USED)) u_flags_a (
    .clock        (clock),
    .rst_n        (rst_n),
    .set_event    (set_a),
    .clear_strobe (clear_a),
    .clear_data   (reg_wdata),
    .mask         (mask_a),
    .flags        (event_flags_a),
    .irq_request  (irq_a)
  );

  tcse_flag_byte #(.USED(`TCSE_FLAGS_B_USED)) u_flags_b (
    .clock        (clock),
    .rst_n        (rst_n),
    .set_event    (set_b),
    .clear_strobe (clear_b),
    .clear_data   (reg_wdata),
    .mask         (mask_b),
    .flags        (event_flags_b_reg),
    .irq_request  (irq_b)
  );

  // ----------------------------------------------------------------
  // interrupt pin and read port
  // ----------------------------------------------------------------
  // pin low while any unmasked flag stands
  always @(posedge clock) begin
    if (!rst_n) begin
      int_n <= 1'b1;
    end else begin
      int_n <= ~(irq_a | irq_b);
    end
  end

  // read mux; unmapped offsets read zero
  always @* begin
    next_rdata = reg_rdata;
    if (reg_read) begin
      case (reg_addr)
        `TCSE_OFS_EXTRA_STATE: next_rdata = extra_state_reg;
        `TCSE_OFS_KIND:        next_rdata = attach_kind;
        `TCSE_OFS_FLAGS_A:     next_rdata = event_flags_a;
        `TCSE_OFS_FLAGS_B:     next_rdata = event_flags_b_reg;
        default:               next_rdata = 8'h00;
      endcase
    end
  end

  // read data held until the next read
  always @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end
endmodule // tcse_status_event_regs

// File: tcse_status_event_regs_properties.sv
// concurrent checks on the status and event bank ports
`timescale 1ns/100ps
module tcse_props (
  input wire       clock,
  input wire       rst_n,
  input wire [7:0] reg_addr,
  input wire       reg_read,
  input wire [7:0] reg_rdata,
  input wire [7:0] mask_a,
  input wire [7:0] mask_b,
  input wire       attached,
  input wire       stabilise_started_event,
  input wire       forced_role_done_event,
  input wire       int_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_unmap; reg_read && reg_addr > 8'h15 |=> reg_rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_xrsv; reg_read && reg_addr == 8'h12 |=> reg_rdata[7:2] == 6'h00; endproperty
  a_xrsv: assert property (p_xrsv) else $error("extra state spare bits set");
  property p_brsv; reg_read && reg_addr == 8'h15 |=> !reg_rdata[7] && !reg_rdata[4]; endproperty
  a_brsv: assert property (p_brsv) else $error("second flags spare bits set");
  property p_hold; !reg_read |=> $stable(reg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved without read");
  property p_mask; $past(mask_a & mask_b) == 8'hFF |-> int_n; endproperty
  a_mask: assert property (p_mask) else $error("masked flags drove interrupt");
  property p_start; stabilise_started_event && !mask_b[0] |-> ##2 !int_n; endproperty
  a_start: assert property (p_start) else $error("start event gave no interrupt");
  property p_done; forced_role_done_event && !mask_b[1] |-> ##2 !int_n; endproperty
  a_done: assert property (p_done) else $error("forced role event gave no interrupt");
  property p_att; $rose(attached) && !mask_a[0] |-> ##2 !int_n; endproperty
  a_att: assert property (p_att) else $error("attach gave no interrupt");
  cover property (stabilise_started_event);
  cover property ($rose(attached));
  cover property (reg_read && reg_addr == 8'h15);
endmodule // tcse_props
bind tcse_status_event_regs tcse_props chk_u (.clock(clock), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_read(reg_read), .reg_rdata(reg_rdata), .mask_a(mask_a),
  .mask_b(mask_b), .attached(attached), .stabilise_started_event(stabilise_started_event),
  .forced_role_done_event(forced_role_done_event), .int_n(int_n));

// File: tcse_host_model.sv
// host side of the register port: one-cycle read and write strobes
`timescale 1ns/100ps
module tcse_host_model (
  input  wire       clock,
  output reg  [7:0] reg_addr,
  output reg        reg_write,
  output reg  [7:0] reg_wdata,
  output reg        reg_read,
  input  wire [7:0] reg_rdata
);
  initial {reg_addr, reg_write, reg_wdata, reg_read} = 18'h0;
  // write strobe, data inverted once released so stale data is not reused
  task wr(input [7:0] a, input [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // read strobe, data taken at the edge after the one that answered
  task rd(input [7:0] a, output [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(posedge clock);
    d = reg_rdata;
  endtask
endmodule // tcse_host_model

// File: tcse_status_event_regs_tb_top.sv
// self-checking bench for the status and event bank
`timescale 1ns/100ps
`define CMP(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED %0t got %h want %h", $time, a, b); end end
module tcse_status_event_regs_tb_top;
  logic       clock = 0, rst_n = 0;
  wire  [7:0] reg_addr, reg_wdata, reg_rdata;
  wire        reg_write, reg_read, int_n;
  logic [6:0] kv = 0;
  logic [5:0] pv = 0;
  logic [1:0] plug_flip_field = 0, advertised_current_level = 0;
  logic [7:0] mask_a = 0, mask_b = 0;
  logic       sink_overrange = 0, stabilise_active_flag = 0, dead_battery_mode = 0;
  logic       bus_supply_valid = 0, bus_supply_low = 1, attached = 0, pulldown_applied = 0;
  wire        debug_accessory_provider, debug_accessory_consumer, attached_consumer;
  wire        attached_provider, powered_cable_flag, headset_powered_flag, headset_unpowered_flag;
  wire        stabilise_supply_off_req, stabilise_supply_on_req, stabilise_failed_event;
  wire        forced_role_failed_event, forced_role_done_event, stabilise_started_event;
  int         n_errors = 0, n_compared = 0;
  // kind levels and event pulses travel as vectors
  assign {debug_accessory_provider, debug_accessory_consumer, attached_consumer,
    attached_provider, powered_cable_flag, headset_powered_flag, headset_unpowered_flag} = kv;
  assign {stabilise_supply_off_req, stabilise_supply_on_req, stabilise_failed_event,
    forced_role_failed_event, forced_role_done_event, stabilise_started_event} = pv;
  tcse_status_event_regs dut_u (.*);
  tcse_host_model host_u (.*);
  initial forever #12.5 clock = ~clock;
  // read one register and compare
  task chk(input [7:0] a, input [7:0] e);
    logic [7:0] d;
    host_u.rd(a, d);
    `CMP(d, e)
  endtask
  // flag must be set and interrupt low, then a clear releases it
  task flag(input [7:0] a, input [7:0] e);
    repeat (3) @(posedge clock);
    chk(a, e);
    `CMP(int_n, 1'b0)
    host_u.wr(a, 8'hFF);
    repeat (3) @(posedge clock);
    `CMP(int_n, 1'b1)
  endtask
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    for (int a = 8'h12; a < 8'h17; a++) chk(a[7:0], 8'h00);
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      @(posedge clock) kv <= 7'h01 << i;
      chk(8'h13, 8'h01 << i);
    end
    @(posedge clock) {kv, sink_overrange, stabilise_active_flag} <= 9'h43;
    chk(8'h12, 8'h03);
    @(posedge clock) kv <= 7'h00;
    chk(8'h12, 8'h01);
    $display("test status done");
    @(posedge clock) attached <= 1'b1;
    flag(8'h14, 8'h01);
    @(posedge clock) attached <= 1'b0;
    flag(8'h14, 8'h02);
    @(posedge clock) advertised_current_level <= 2'h2;
    flag(8'h14, 8'h04);
    @(posedge clock) dead_battery_mode <= 1'b1;
    flag(8'h14, 8'h08);
    @(posedge clock) bus_supply_valid <= 1'b1;
    flag(8'h14, 8'h10);
    @(posedge clock) pulldown_applied <= 1'b1;
    flag(8'h14, 8'h20);
    @(posedge clock) plug_flip_field <= 2'h1;
    flag(8'h14, 8'h40);
    @(posedge clock) plug_flip_field <= 2'h0;
    @(posedge clock) plug_flip_field <= 2'h3;
    repeat (3) @(posedge clock);
    chk(8'h14, 8'h00);
    @(posedge clock) plug_flip_field <= 2'h0;
    @(posedge clock) plug_flip_field <= 2'h2;
    flag(8'h14, 8'h40);
    @(posedge clock) bus_supply_low <= 1'b0;
    flag(8'h14, 8'h10);
    @(posedge clock) dead_battery_mode <= 1'b0;
    flag(8'h14, 8'h08);
    $display("test first flags done");
    for (int i = 0; i < 6; i++) begin
      @(posedge clock) pv <= 6'h01 << i;
      @(posedge clock) pv <= 6'h00;
      flag(8'h15, (i > 3) ? 8'h02 << i : 8'h01 << i);
    end
    @(posedge clock) pv <= 6'h03;
    @(posedge clock) pv <= 6'h00;
    host_u.wr(8'h15, 8'h00);
    chk(8'h15, 8'h03);
    host_u.wr(8'h15, 8'h01);
    chk(8'h15, 8'h02);
    @(posedge clock) {mask_a, mask_b} <= 16'hFFFF;
    repeat (3) @(posedge clock);
    `CMP(int_n, 1'b1)
    chk(8'h15, 8'h02);
    @(posedge clock) {mask_a, mask_b} <= 16'h0000;
    flag(8'h15, 8'h02);
    $display("test second flags done");
    test_done;
  end
  // watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge clock);
    n_errors++;
    $display("watchdog expired");
    test_done;
  end
endmodule // tcse_status_event_regs_tb_top
